// File: rtl/liutj_map.svh
`ifndef LIUTJ_MAP_SVH
`define LIUTJ_MAP_SVH

// ==========================================================================
// Register offsets on the host port
`define LIUTJ_ADDR_TX_TEST      8'h02
`define LIUTJ_ADDR_LINE_JIT     8'h03
`define LIUTJ_ADDR_STATUS       8'h10

// ==========================================================================
// Reset values
`define LIUTJ_TX_TEST_RESET     8'h00
`define LIUTJ_LINE_JIT_RESET    8'h00

// ==========================================================================
// transmit_test_control fields
`define LIUTJ_FORCE_ALL_ONES_N  7
`define LIUTJ_AUTO_ALL_ONES     6
`define LIUTJ_ALTERNATING       5
`define LIUTJ_PSEUDO_RANDOM     4
`define LIUTJ_LOOP_CODE         3
`define LIUTJ_LINE_IF_RESET     2
`define LIUTJ_VIOLATION_INSERT  1
`define LIUTJ_ERROR_INSERT      0

// ==========================================================================
// line_jitter_control fields
`define LIUTJ_BUILD_OUT_HI      7
`define LIUTJ_BUILD_OUT_LO      5
`define LIUTJ_EQ_GAIN_LIMIT     4
`define LIUTJ_ATTEN_PATH        3
`define LIUTJ_ATTEN_DEPTH       2
`define LIUTJ_ATTEN_DISABLE     1
`define LIUTJ_TX_POWER_DOWN     0

// ==========================================================================
// Carrier loss thresholds (consecutive zeros), buffer depths and ones counted before a violation
`define LIUTJ_LOSS_E1           12'h0FF
`define LIUTJ_LOSS_T1           12'h0C0
`define LIUTJ_LOSS_ALT_E1       12'h800
`define LIUTJ_LOSS_ALT_T1       12'h608
`define LIUTJ_DEPTH_LONG        8'h80
`define LIUTJ_DEPTH_SHORT       8'h20
`define LIUTJ_BPV_ONES          2'h2

`endif

// File: rtl/liutj_pkg.sv
package liutj_pkg;

  // Transmit pattern sources, highest priority first
  typedef enum logic [2:0] {
    SRC_FORCE,
    SRC_AUTO,
    SRC_ALT,
    SRC_PRBS,
    SRC_LOOP,
    SRC_DATA
  } liutj_src_e;

endpackage

// File: rtl/liutj_fifo.sv
`timescale 1ns/1ns
module liutj_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_ff];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// File: rtl/liutj_prbs.sv
`timescale 1ns/1ns
module liutj_prbs (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic stepEn,
  input  wire logic modeT1,
  output logic      patternBit
);

  // E1: 15-stage sequence; T1: 20-stage with long zero runs suppressed
  logic [19:0] lfsr_ff;
  logic        feedback;
  logic        lockup;

  assign lockup   = modeT1 ? (lfsr_ff == '0) : (lfsr_ff[14:0] == '0);
  assign feedback = lockup | (modeT1 ? (lfsr_ff[19] ^ lfsr_ff[16])
                                     : (lfsr_ff[14] ^ lfsr_ff[13]));
  assign patternBit = modeT1 ? (lfsr_ff[19] | (lfsr_ff[18:5] == '0))
                             : lfsr_ff[14];

  always_ff @(posedge clock) begin
    if (reset) begin
      lfsr_ff <= 20'h00001;
    end else if (stepEn) begin
      lfsr_ff <= {lfsr_ff[18:0], feedback};
    end
  end

endmodule

// File: rtl/liutj_top.sv
// Contract
// - Force bit 0 sends unframed all ones
// - Force bit resets to all-ones state
// - Forced ones timed by attenuator clock
// - Auto ones on carrier loss when enabled
// - Alternating 1010 timed by transmit clock
// - PRBS 2^15-1 in E1, QRSS in T1
// - Loop code repeats code definition registers
// - Reset bit rise resets recovery, recentres buffer
// - Violation on third of next three consecutive ones
// - Error bit rise inverts one bit
// - Three build-out bits select pulse shape
// - Gain-limit bit selects equalizer sensitivity
// - Path bit: receive at 0, transmit 1
// - Depth bit: 128 bits at 0, 32 at 1
// - Disable bit bypasses jitter attenuator
// - Power-down bit tri-states line outputs
// - Carrier loss on 255/192 or 2048/1544 zeros
`timescale 1ns/1ns
`include "liutj_map.svh"

module liutj_top
  import liutj_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] hostAddr,
  input  wire logic       hostWrite,
  input  wire logic       hostRead,
  input  wire logic [7:0] hostWrData,
  output logic      [7:0] hostRdData,
  input  wire logic       modeT1,
  input  wire logic       lossAltCriterion,
  input  wire logic       txClockEn,
  input  wire logic       attenClockEn,
  input  wire logic [7:0] txCodeDef1,
  input  wire logic [7:0] txCodeDef2,
  input  wire logic       txDataIn,
  input  wire logic       txDataValid,
  output logic            txDataReady,
  input  wire logic       rxBitIn,
  input  wire logic       rxBitEn,
  output logic            receiveCarrierLoss,
  output logic            lineOutTip,
  output logic            lineOutRing,
  output logic            lineOutEnable,
  output logic            lineInterfaceResetPulse,
  output logic      [2:0] buildOutSel,
  output logic            equalizerGainLimit,
  output logic            attenuatorPathSel,
  output logic      [7:0] attenuatorDepth,
  output logic            attenuatorDisable,
  output logic            transmitPowerDown
);

  // ========================================================================
  // Declarations
  logic [7:0]  txTest_ff;
  logic [7:0]  lineJit_ff;
  logic [7:0]  hostRdData_ff;
  logic        lirstPulse_ff;
  logic        bpvPending_ff;
  logic        errPending_ff;
  logic [1:0]  onesRun_ff;
  logic        lastMarkPos_ff;
  logic        tip_ff;
  logic        ring_ff;
  logic        lineEn_ff;
  logic        altPhase_ff;
  logic [3:0]  loopIdx_ff;
  logic [11:0] zeroCount_ff;
  logic        carrierLoss_ff;
  logic        wrTxTest;
  logic        wrLineJit;
  logic [7:0]  riseBits;
  logic [7:0]  nxt_rdData;
  liutj_src_e  nxt_src;
  logic        tick;
  logic        rawBit;
  logic        txBit;
  logic        violation;
  logic        markPos;
  logic        prbsBit;
  logic        fifoBit;
  logic        fifoValid;
  logic        fifoReady;
  logic [15:0] loopCode;
  logic [11:0] lossLimit;
  logic [11:0] zeroNext;

  // ========================================================================
  // Host register writes
  assign wrTxTest  = hostWrite && (hostAddr == `LIUTJ_ADDR_TX_TEST);
  assign wrLineJit = hostWrite && (hostAddr == `LIUTJ_ADDR_LINE_JIT);
  // Only bits that go from stored 0 to written 1 count as edges
  assign riseBits  = hostWrData & ~txTest_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      txTest_ff <= `LIUTJ_TX_TEST_RESET;
    end else if (wrTxTest) begin
      txTest_ff <= hostWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lineJit_ff <= `LIUTJ_LINE_JIT_RESET;
    end else if (wrLineJit) begin
      lineJit_ff <= hostWrData;
    end
  end

  // ========================================================================
  // Host register reads
  always_comb begin
    case (hostAddr)
      `LIUTJ_ADDR_TX_TEST:  nxt_rdData = txTest_ff;
      `LIUTJ_ADDR_LINE_JIT: nxt_rdData = lineJit_ff;
      `LIUTJ_ADDR_STATUS:   nxt_rdData = {4'h0, ~txDataReady,
                                          bpvPending_ff, errPending_ff,
                                          carrierLoss_ff};
      default:              nxt_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hostRdData_ff <= 8'h00;
    end else if (hostRead) begin
      hostRdData_ff <= nxt_rdData;
    end
  end
  assign hostRdData = hostRdData_ff;

  // ========================================================================
  // Line interface reset
  // A bit held at 1 gives no new edge, so software must write 0 first
  always_ff @(posedge clock) begin
    if (reset) begin
      lirstPulse_ff <= 1'b0;
    end else begin
      lirstPulse_ff <= wrTxTest && riseBits[`LIUTJ_LINE_IF_RESET];
    end
  end
  assign lineInterfaceResetPulse = lirstPulse_ff;

  // ========================================================================
  // Line and attenuator controls
  assign buildOutSel        = lineJit_ff[`LIUTJ_BUILD_OUT_HI:
                                         `LIUTJ_BUILD_OUT_LO];
  assign equalizerGainLimit = lineJit_ff[`LIUTJ_EQ_GAIN_LIMIT];
  assign attenuatorPathSel  = lineJit_ff[`LIUTJ_ATTEN_PATH];
  assign attenuatorDisable  = lineJit_ff[`LIUTJ_ATTEN_DISABLE];
  assign transmitPowerDown  = lineJit_ff[`LIUTJ_TX_POWER_DOWN];
  assign attenuatorDepth    = lineJit_ff[`LIUTJ_ATTEN_DEPTH]
                              ? `LIUTJ_DEPTH_SHORT
                              : `LIUTJ_DEPTH_LONG;

  // ========================================================================
  // Receive carrier loss
  always_comb begin
    case ({lossAltCriterion, modeT1})
      2'b00:   lossLimit = `LIUTJ_LOSS_E1;
      2'b01:   lossLimit = `LIUTJ_LOSS_T1;
      2'b10:   lossLimit = `LIUTJ_LOSS_ALT_E1;
      2'b11:   lossLimit = `LIUTJ_LOSS_ALT_T1;
      default: lossLimit = `LIUTJ_LOSS_E1;
    endcase
  end

  // Saturates at the limit so a long outage cannot wrap and clear loss
  assign zeroNext = (zeroCount_ff >= lossLimit) ? zeroCount_ff
                                                : zeroCount_ff + 12'h001;

  always_ff @(posedge clock) begin
    if (reset) begin
      zeroCount_ff   <= 12'h000;
      carrierLoss_ff <= 1'b0;
    end else if (rxBitEn) begin
      if (rxBitIn) begin
        zeroCount_ff   <= 12'h000;
        carrierLoss_ff <= 1'b0;
      end else begin
        zeroCount_ff   <= zeroNext;
        carrierLoss_ff <= (zeroNext >= lossLimit);
      end
    end
  end
  assign receiveCarrierLoss = carrierLoss_ff;

  // ========================================================================
  // Pattern source selection
  always_comb begin
    if (!txTest_ff[`LIUTJ_FORCE_ALL_ONES_N]) begin
      nxt_src = SRC_FORCE;
    end else if (txTest_ff[`LIUTJ_AUTO_ALL_ONES] && carrierLoss_ff) begin
      nxt_src = SRC_AUTO;
    end else if (txTest_ff[`LIUTJ_ALTERNATING]) begin
      nxt_src = SRC_ALT;
    end else if (txTest_ff[`LIUTJ_PSEUDO_RANDOM]) begin
      nxt_src = SRC_PRBS;
    end else if (txTest_ff[`LIUTJ_LOOP_CODE]) begin
      nxt_src = SRC_LOOP;
    end else begin
      nxt_src = SRC_DATA;
    end
  end

  // All-ones runs off the attenuator clock so it survives a dead
  // transmit clock; every other source follows the transmit clock
  always_comb begin
    case (nxt_src)
      SRC_FORCE: tick = attenClockEn;
      SRC_AUTO:  tick = attenClockEn;
      default:   tick = txClockEn;
    endcase
  end

  // ========================================================================
  // Pattern generators
  always_ff @(posedge clock) begin
    if (reset) begin
      altPhase_ff <= 1'b1;
    end else if (tick && nxt_src == SRC_ALT) begin
      altPhase_ff <= ~altPhase_ff;
    end
  end

  liutj_prbs u_prbs (
    .clock      (clock),
    .reset      (reset),
    .stepEn     (tick && nxt_src == SRC_PRBS),
    .modeT1     (modeT1),
    .patternBit (prbsBit)
  );

  assign loopCode = {txCodeDef1, txCodeDef2};

  // Code restarts from its first bit each time loop mode is entered
  always_ff @(posedge clock) begin
    if (reset) begin
      loopIdx_ff <= 4'hF;
    end else if (nxt_src != SRC_LOOP) begin
      loopIdx_ff <= 4'hF;
    end else if (tick) begin
      loopIdx_ff <= loopIdx_ff - 4'h1;
    end
  end

  // ========================================================================
  // Transmit data buffer
  assign fifoReady = tick && (nxt_src == SRC_DATA);

  liutj_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .reset    (reset),
    .inData   (txDataIn),
    .inValid  (txDataValid),
    .inReady  (txDataReady),
    .outData  (fifoBit),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // ========================================================================
  // Bit mux and error insertion
  always_comb begin
    case (nxt_src)
      SRC_FORCE: rawBit = 1'b1;
      SRC_AUTO:  rawBit = 1'b1;
      SRC_ALT:   rawBit = altPhase_ff;
      SRC_PRBS:  rawBit = prbsBit;
      SRC_LOOP:  rawBit = loopCode[loopIdx_ff];
      SRC_DATA:  rawBit = fifoValid & fifoBit;
      default:   rawBit = 1'b1;
    endcase
  end

  assign txBit = rawBit ^ errPending_ff;

  // New rising write wins over consumption in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      errPending_ff <= 1'b0;
    end else if (wrTxTest && riseBits[`LIUTJ_ERROR_INSERT]) begin
      errPending_ff <= 1'b1;
    end else if (tick) begin
      errPending_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Bipolar violation insertion
  assign violation = bpvPending_ff && txBit &&
                     (onesRun_ff == `LIUTJ_BPV_ONES);
  assign markPos   = violation ? lastMarkPos_ff : ~lastMarkPos_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      bpvPending_ff <= 1'b0;
    end else if (wrTxTest && riseBits[`LIUTJ_VIOLATION_INSERT]) begin
      bpvPending_ff <= 1'b1;
    end else if (tick && violation) begin
      bpvPending_ff <= 1'b0;
    end
  end

  // Ones are counted only once armed, so older ones never count
  always_ff @(posedge clock) begin
    if (reset) begin
      onesRun_ff <= 2'h0;
    end else if (!bpvPending_ff ||
                 (wrTxTest && riseBits[`LIUTJ_VIOLATION_INSERT])) begin
      onesRun_ff <= 2'h0;
    end else if (tick) begin
      onesRun_ff <= txBit ? onesRun_ff + 2'h1 : 2'h0;
    end
  end

  // ========================================================================
  // Line encoder and driver
  always_ff @(posedge clock) begin
    if (reset) begin
      lastMarkPos_ff <= 1'b0;
    end else if (tick && txBit) begin
      lastMarkPos_ff <= markPos;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tip_ff  <= 1'b0;
      ring_ff <= 1'b0;
    end else if (transmitPowerDown) begin
      tip_ff  <= 1'b0;
      ring_ff <= 1'b0;
    end else if (tick) begin
      tip_ff  <= txBit && markPos;
      ring_ff <= txBit && !markPos;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lineEn_ff <= 1'b1;
    end else begin
      lineEn_ff <= !transmitPowerDown;
    end
  end

  assign lineOutTip    = tip_ff;
  assign lineOutRing   = ring_ff;
  assign lineOutEnable = lineEn_ff;

endmodule

// File: bench/liutj_top_chk.sv
`timescale 1ns/1ns
// ==========================================================================
// Port checker for the transmit test and jitter control registers
module liutj_top_chk (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] hostAddr,
  input wire logic       hostWrite,
  input wire logic [7:0] hostWrData,
  input wire logic       txClockEn,
  input wire logic       attenClockEn,
  input wire logic       rxBitIn,
  input wire logic       rxBitEn,
  input wire logic       receiveCarrierLoss,
  input wire logic       lineOutTip,
  input wire logic       lineOutRing,
  input wire logic       lineOutEnable,
  input wire logic       lineInterfaceResetPulse,
  input wire logic [2:0] buildOutSel,
  input wire logic       equalizerGainLimit,
  input wire logic       attenuatorPathSel,
  input wire logic [7:0] attenuatorDepth,
  input wire logic       attenuatorDisable,
  input wire logic       transmitPowerDown
);
  logic [7:0] txCtl_ff;
  logic [7:0] wrData_ff;
  logic       wrTx;
  logic       wrLine;
  logic       rstRise;

  assign wrTx    = hostWrite && hostAddr == 8'h02;
  assign wrLine  = hostWrite && hostAddr == 8'h03;
  assign rstRise = wrTx && hostWrData[2] && !txCtl_ff[2];

  // Shadow of the test register, so a rise can be told from a held level
  always_ff @(posedge clock) begin
    if (reset) begin
      txCtl_ff <= 8'h00;
    end else if (wrTx) begin
      txCtl_ff <= hostWrData;
    end
  end

  always_ff @(posedge clock) begin
    wrData_ff <= hostWrData;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence pulseOnce;
    lineInterfaceResetPulse ##1 !lineInterfaceResetPulse;
  endsequence

  // ==========================================================================
  // Assertions
  chk_reset_pulse: assert property (rstRise |=> pulseOnce)
    else $error("reset pulse missing");
  chk_pulse_cause: assert property (
    lineInterfaceResetPulse |-> $past(rstRise))
    else $error("reset pulse without a rise");
  chk_build_out: assert property (
    wrLine |=> buildOutSel == wrData_ff[7:5])
    else $error("build-out field wrong");
  chk_gain_limit: assert property (
    wrLine |=> equalizerGainLimit == wrData_ff[4])
    else $error("gain limit wrong");
  chk_path_sel: assert property (
    wrLine |=> attenuatorPathSel == wrData_ff[3])
    else $error("path select wrong");
  chk_buffer_depth: assert property (
    wrLine |=> attenuatorDepth == (wrData_ff[2] ? 8'h20 : 8'h80))
    else $error("buffer depth wrong");
  chk_atten_disable: assert property (
    wrLine |=> attenuatorDisable == wrData_ff[1])
    else $error("attenuator disable wrong");
  chk_power_down: assert property (
    transmitPowerDown |=> !lineOutEnable && !lineOutTip && !lineOutRing)
    else $error("line driven in power-down");
  chk_forced_ones: assert property (
    !txCtl_ff[7] && attenClockEn && !transmitPowerDown
    |=> lineOutTip || lineOutRing)
    else $error("forced ones missing");
  chk_forced_clock: assert property (
    !txCtl_ff[7] && txClockEn && !attenClockEn
    |=> $stable({lineOutTip, lineOutRing}))
    else $error("forced ones moved on transmit clock");
  chk_loss_clear: assert property (
    rxBitEn && rxBitIn |=> !receiveCarrierLoss)
    else $error("carrier loss held after a mark");
endmodule

bind liutj_top liutj_top_chk chk (
  .clock(clock), .reset(reset), .hostAddr(hostAddr),
  .hostWrite(hostWrite), .hostWrData(hostWrData), .txClockEn(txClockEn),
  .attenClockEn(attenClockEn), .rxBitIn(rxBitIn), .rxBitEn(rxBitEn),
  .receiveCarrierLoss(receiveCarrierLoss), .lineOutTip(lineOutTip),
  .lineOutRing(lineOutRing), .lineOutEnable(lineOutEnable),
  .lineInterfaceResetPulse(lineInterfaceResetPulse),
  .buildOutSel(buildOutSel), .equalizerGainLimit(equalizerGainLimit),
  .attenuatorPathSel(attenuatorPathSel), .attenuatorDepth(attenuatorDepth),
  .attenuatorDisable(attenuatorDisable),
  .transmitPowerDown(transmitPowerDown)
);

// File: bench/test_liu_transmit_test_and_jitter_control.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module test_liu_transmit_test_and_jitter_control;
  logic       clock, reset, hostWrite, hostRead, modeT1, lossAlt;
  logic       txClockEn, attenClockEn, txDataIn, txDataValid, txDataReady;
  logic       rxBitIn, rxBitEn, loss, tip, ring, lineEn, rstPulse;
  logic       gainLim, pathSel, attDis, pwrDown;
  logic [7:0] hostAddr, hostWrData, hostRdData, attDepth;
  logic [2:0] buildOut;
  logic [1:0] m, m0, m1;
  logic [14:0] lfsr;
  int         error_cnt, n_checks, cycles;
  // Small FIFO so the full case is cheap to reach
  localparam logic [7:0] CODE1 = 8'hB4;
  localparam logic [7:0] CODE2 = 8'h2D;
  localparam logic [15:0] CODE = {CODE1, CODE2};
  int         lossN [4] = '{255, 192, 2048, 1544};
  logic [7:0] rows [8][3] = '{'{8'h03, 8'hE0, 8'hE0}, '{8'h03, 8'h1F, 8'h1F},
    '{8'h03, 8'h14, 8'h14}, '{8'h03, 8'h01, 8'h01}, '{8'h03, 8'h0A, 8'h0A},
    '{8'h01, 8'hFF, 8'h00}, '{8'h20, 8'h5A, 8'h00}, '{8'h02, 8'h80, 8'h80}};

  liutj_top #(.FIFO_DEPTH(4)) dut (
    .clock(clock), .reset(reset), .hostAddr(hostAddr),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
    .hostRdData(hostRdData), .modeT1(modeT1), .lossAltCriterion(lossAlt),
    .txClockEn(txClockEn), .attenClockEn(attenClockEn),
    .txCodeDef1(CODE1), .txCodeDef2(CODE2), .txDataIn(txDataIn),
    .txDataValid(txDataValid), .txDataReady(txDataReady),
    .rxBitIn(rxBitIn), .rxBitEn(rxBitEn), .receiveCarrierLoss(loss),
    .lineOutTip(tip), .lineOutRing(ring), .lineOutEnable(lineEn),
    .lineInterfaceResetPulse(rstPulse), .buildOutSel(buildOut),
    .equalizerGainLimit(gainLim), .attenuatorPathSel(pathSel),
    .attenuatorDepth(attDepth), .attenuatorDisable(attDis),
    .transmitPowerDown(pwrDown)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================================================
  // Bus and stream helpers, all driven on the falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    hostWrite = 1'b1;
    hostAddr = a;
    hostWrData = d;
    @(negedge clock);
    hostWrite = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    hostRead = 1'b1;
    hostAddr = a;
    @(negedge clock);
    hostRead = 1'b0;
    `CHK("readData", e, hostRdData)
  endtask

  task tick(input logic atten, output logic [1:0] mk);
    @(negedge clock);
    attenClockEn = atten;
    txClockEn = ~atten;
    @(negedge clock);
    attenClockEn = 1'b0;
    txClockEn = 1'b0;
    mk = {tip, ring};
  endtask

  task push(input logic b);
    int w;
    w = 0;
    @(negedge clock);
    txDataValid = 1'b1;
    txDataIn = b;
    while (txDataReady !== 1'b1 && w < 50) begin
      @(negedge clock);
      w++;
    end
    @(negedge clock);
    txDataValid = 1'b0;
  endtask

  task rx(input logic b);
    @(negedge clock);
    rxBitEn = 1'b1;
    rxBitIn = b;
    @(negedge clock);
    rxBitEn = 1'b0;
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cut a hang short well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("wrong value timeout expected 0 seen %0d", cycles);
      final_report();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {hostWrite, hostRead, modeT1, lossAlt, txClockEn, attenClockEn} = '0;
    {txDataIn, txDataValid, rxBitIn, rxBitEn} = '0;
    {hostAddr, hostWrData} = '0;
    reset = 1'b1;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
      if (rows[i][0] == 8'h03) begin
        `CHK("buildOut", rows[i][1][7:5], buildOut)
        `CHK("gainLimit", rows[i][1][4], gainLim)
        `CHK("pathSel", rows[i][1][3], pathSel)
        `CHK("depth", rows[i][1][2] ? 8'h20 : 8'h80, attDepth)
        `CHK("disable", rows[i][1][1], attDis)
        `CHK("lineEn", ~rows[i][1][0], lineEn)
        `CHK("powerDown", rows[i][1][0], pwrDown)
      end
    end
    done("registers");
    // Second reset in mid-run restores the all-ones default
    @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    `CHK("depthReset", 8'h80, attDepth)
    `CHK("pathReset", 1'b0, pathSel)
    repeat (3) begin
      tick(1'b0, m);
      `CHK("forcedOnTx", 2'b00, m)
    end
    tick(1'b1, m);
    `CHK("forcedFirst", 2'b10, m)
    tick(1'b1, m);
    `CHK("forcedSecond", 2'b01, m)
    wr(8'h03, 8'h01);
    tick(1'b1, m);
    `CHK("pdMark", 2'b00, m)
    `CHK("pdEnable", 1'b0, lineEn)
    wr(8'h03, 8'h00);
    @(negedge clock);
    `CHK("pdRelease", 1'b1, lineEn)
    done("reset and forced ones");
    wr(8'h02, 8'h04);
    `CHK("rstRise", 1'b1, rstPulse)
    @(negedge clock);
    `CHK("rstOnce", 1'b0, rstPulse)
    wr(8'h02, 8'h04);
    `CHK("rstHeld", 1'b0, rstPulse)
    wr(8'h02, 8'h00);
    wr(8'h02, 8'h04);
    `CHK("rstAgain", 1'b1, rstPulse)
    done("line reset");
    // Fill until refused with no ticks, then drain
    wr(8'h02, 8'h80);
    for (int i = 0; i < 4; i++) push(i != 1);
    `CHK("fifoFull", 1'b0, txDataReady)
    for (int i = 0; i < 4; i++) begin
      tick(1'b0, m);
      `CHK("dataBit", i != 1, |m)
    end
    `CHK("fifoFree", 1'b1, txDataReady)
    tick(1'b0, m);
    `CHK("emptyBit", 1'b0, |m)
    push(1'b1);
    push(1'b0);
    wr(8'h02, 8'h81);
    tick(1'b0, m);
    `CHK("errInverted", 1'b0, |m)
    tick(1'b0, m);
    `CHK("errOnce", 1'b0, |m)
    wr(8'h02, 8'h80);
    wr(8'h02, 8'h82);
    repeat (4) push(1'b1);
    tick(1'b0, m0);
    tick(1'b0, m1);
    tick(1'b0, m);
    `CHK("bpvAlternate", {m0[0], m0[1]}, m1)
    `CHK("bpvThird", m1, m)
    tick(1'b0, m);
    `CHK("bpvAfter", {m1[0], m1[1]}, m)
    done("data path");
    for (int k = 0; k < 4; k++) begin
      modeT1 = k[0];
      lossAlt = k[1];
      rx(1'b1);
      repeat (lossN[k] - 1) rx(1'b0);
      `CHK("lossEarly", 1'b0, loss)
      rx(1'b0);
      `CHK("lossSet", 1'b1, loss)
      rx(1'b1);
      `CHK("lossClear", 1'b0, loss)
    end
    lossAlt = 1'b0;
    repeat (192) rx(1'b0);
    wr(8'h02, 8'hC0);
    tick(1'b1, m);
    `CHK("autoOnes", 1'b1, |m)
    rd(8'h10, 8'h01);
    wr(8'h02, 8'hE0);
    repeat (2) begin
      tick(1'b1, m);
      `CHK("autoOverAlt", 1'b1, |m)
    end
    rx(1'b1);
    tick(1'b0, m0);
    repeat (3) begin
      tick(1'b0, m);
      `CHK("altStep", ~(|m0), |m)
      m0 = m;
    end
    done("carrier loss and patterns");
    wr(8'h02, 8'h80);
    wr(8'h02, 8'h88);
    for (int i = 15; i >= 0; i--) begin
      tick(1'b0, m);
      `CHK("loopCode", CODE[i], |m)
    end
    done("loop code");
    // E1 sequence against a model of the 15-stage register from its seed
    modeT1 = 1'b0;
    wr(8'h02, 8'h90);
    lfsr = 15'h0001;
    for (int i = 0; i < 32; i++) begin
      tick(1'b0, m);
      `CHK("prbsBit", lfsr[14], |m)
      lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
    end
    done("pseudo-random");
    final_report();
  end
endmodule
